// >>> include/srol_pkg.sv
// shared constants for the shift register with output latch
package srol_pkg;
  localparam int SROL_WIDTH = 8;
  localparam int SROL_FIFO_DEPTH = 2;
  localparam int SROL_PIN_COUNT = 5;
  // pin positions inside the synchroniser vector
  localparam int SROL_PIN_DATA = 0;
  localparam int SROL_PIN_SCLK = 1;
  localparam int SROL_PIN_SCLR = 2;
  localparam int SROL_PIN_TCLK = 3;
  localparam int SROL_PIN_TCLR = 4;
  // reset values and the full buffer count
  localparam logic [SROL_WIDTH-1:0] SROL_SHIFT_RST = 8'h00;
  localparam logic [SROL_WIDTH-1:0] SROL_STORE_RST = 8'h00;
  localparam logic [SROL_PIN_COUNT-1:0] SROL_SYNC_RST = 5'h00;
  localparam logic [1:0] SROL_COUNT_RST = 2'h0;
  localparam logic [1:0] SROL_COUNT_FULL = 2'h2;
endpackage

// >>> verilog/srol_fifo2.sv
// two-entry buffer for captured storage words
`timescale 1ns/1ps
`default_nettype none
module srol_fifo2
  import srol_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [SROL_WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [SROL_WIDTH-1:0] o_out_data
);
  logic [SROL_WIDTH-1:0] mem_reg [SROL_FIFO_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != SROL_COUNT_FULL);
  assign o_out_valid = (count_reg != SROL_COUNT_RST);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_reg[0] <= SROL_STORE_RST;
      mem_reg[1] <= SROL_STORE_RST;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= SROL_COUNT_RST;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'h1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'h1;
    end
  end
endmodule // srol_fifo2
`default_nettype wire

// >>> verilog/srol_top.sv
// eight-bit shift register feeding an eight-bit storage register
// How it works
// R1: eight-stage serial shift register copied in parallel into storage register.
// R2: shift clear low empties every shift stage whatever else happens.
// R3: shift clock rise with clear high shifts serial input into stage one.
// R4: shift clock fall changes nothing; only rises advance the shift register.
// R5: storage clear low empties the storage register independent of everything.
// R6: storage clock rise with clear high copies shift stages into storage.
// R7: storage clock fall leaves the storage register unchanged.
// R8: each register has own clock and clear; clear overrides clock.
// R9: with tied clocks, storage takes shift contents from before the edge.
// R10: cascade output carries shifted data on to the next device.
// R11: cascade follows last stage; parallel outputs show storage, stage one lowest.
// R12: controller sets data before shift rise, eight shifts, then storage pulse.
`timescale 1ns/1ps
`default_nettype none
module srol_top
  import srol_pkg::*;
(
  // system
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // controller pins
  input wire logic i_serial_in,
  input wire logic i_shift_clock,
  input wire logic i_shift_clear_n,
  input wire logic i_storage_clock,
  input wire logic i_storage_clear_n,
  // device pins
  output logic o_cascade_out,
  output logic [SROL_WIDTH-1:0] o_parallel_out,
  // captured word stream
  output logic o_load_ready,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [SROL_WIDTH-1:0] o_word_data
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SROL_PIN_COUNT-1:0] pins;
  logic [SROL_PIN_COUNT-1:0] sync1_reg;
  logic [SROL_PIN_COUNT-1:0] sync2_reg;
  logic sclk_prev_reg;
  logic tclk_prev_reg;

  assign pins[SROL_PIN_DATA] = i_serial_in;
  assign pins[SROL_PIN_SCLK] = i_shift_clock;
  assign pins[SROL_PIN_SCLR] = i_shift_clear_n;
  assign pins[SROL_PIN_TCLK] = i_storage_clock;
  assign pins[SROL_PIN_TCLR] = i_storage_clear_n;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= SROL_SYNC_RST;
      sync2_reg <= SROL_SYNC_RST;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // clock pins are sampled, so each needs about two system clocks per level
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_reg <= 1'b0;
      tclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sync2_reg[SROL_PIN_SCLK];
      tclk_prev_reg <= sync2_reg[SROL_PIN_TCLK];
    end
  end

  logic sdata;
  logic shift_clr_n;
  logic store_clr_n;
  logic shift_rise;
  logic store_rise;

  assign sdata = sync2_reg[SROL_PIN_DATA];
  assign shift_clr_n = sync2_reg[SROL_PIN_SCLR];
  assign store_clr_n = sync2_reg[SROL_PIN_TCLR];
  // falling edges are simply never decoded
  assign shift_rise = sync2_reg[SROL_PIN_SCLK] && !sclk_prev_reg; // R4
  assign store_rise = sync2_reg[SROL_PIN_TCLK] && !tclk_prev_reg; // R7

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  logic [SROL_WIDTH-1:0] shift_reg;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SROL_SHIFT_RST;
    end else if (!shift_clr_n) begin
      shift_reg <= SROL_SHIFT_RST; // R2 R8
    end else if (shift_rise) begin
      shift_reg <= {shift_reg[SROL_WIDTH-2:0], sdata}; // R1 R3
    end
  end

  // ----------------------------------------------------------------
  // storage register
  // ----------------------------------------------------------------
  logic [SROL_WIDTH-1:0] store_reg;
  logic store_load;

  assign store_load = store_rise && store_clr_n;

  // non-blocking read of shift_reg gives the pre-edge value for tied clocks
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_reg <= SROL_STORE_RST;
    end else if (!store_clr_n) begin
      store_reg <= SROL_STORE_RST; // R5 R8
    end else if (store_rise) begin
      store_reg <= shift_reg; // R1 R6 R9
    end
  end

  assign o_cascade_out = shift_reg[SROL_WIDTH-1]; // R10 R11
  assign o_parallel_out = store_reg; // R11

  // ----------------------------------------------------------------
  // word buffer
  // ----------------------------------------------------------------
  // a load that finds the buffer full still updates the pins; the
  // stream copy is dropped, which o_load_ready low warns about
  srol_fifo2 srol_fifo2_i (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_in_valid(store_load),
    .o_in_ready(o_load_ready),
    .i_in_data(shift_reg),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_shift_edge;
    shift_rise && shift_clr_n;
  endsequence

  sequence seq_store_edge;
    store_rise && store_clr_n;
  endsequence

  chk_shift_clear: assert property ( // R2
    !shift_clr_n |=> shift_reg == SROL_SHIFT_RST)
    else $error("shift register not cleared");

  chk_shift_step: assert property ( // R3
    seq_shift_edge |=>
      shift_reg == {$past(shift_reg[SROL_WIDTH-2:0]), $past(sdata)})
    else $error("shift step wrong");

  chk_shift_hold: assert property ( // R4
    (!shift_rise && shift_clr_n) |=> $stable(shift_reg))
    else $error("shift register moved without rising edge");

  chk_clear_override: assert property ( // R8
    (shift_rise && !shift_clr_n) |=> shift_reg == SROL_SHIFT_RST)
    else $error("shift clear did not override clock");

  chk_store_override: assert property ( // R8
    (store_rise && !store_clr_n) |=> o_parallel_out == SROL_STORE_RST)
    else $error("storage clear did not override clock");

  chk_store_clear: assert property ( // R5
    !store_clr_n |=> o_parallel_out == SROL_STORE_RST)
    else $error("storage register not cleared");

  chk_store_copy: assert property ( // R6
    seq_store_edge |=> o_parallel_out == $past(shift_reg))
    else $error("storage copy wrong");

  chk_store_hold: assert property ( // R7
    (!store_rise && store_clr_n) |=> $stable(o_parallel_out))
    else $error("storage changed without rising edge");

  chk_tied_lag: assert property ( // R9
    (seq_shift_edge and seq_store_edge) |=>
      o_parallel_out == $past(shift_reg) &&
      shift_reg == {o_parallel_out[SROL_WIDTH-2:0], $past(sdata)})
    else $error("storage did not lag shift register");

  chk_cascade_delay: assert property ( // R10
    seq_shift_edge |=> o_cascade_out == $past(shift_reg[SROL_WIDTH-2]))
    else $error("cascade output out of step");

  // two synchroniser stages put the decoded rise two edges after the pin
  chk_pin_latency: assert property ( // R3
    $rose(i_shift_clock) |-> ##2 shift_rise)
    else $error("shift clock rise not decoded in time");

  chk_out_source: assert property ( // R11
    (o_parallel_out != $past(o_parallel_out)) |->
      ($past(store_rise) || $past(!store_clr_n)))
    else $error("outputs changed without storage edge");
endmodule // srol_top
`default_nettype wire

// >>> verif/srol_ctrl_model.sv
// controller model driving the serial and clock pins
`timescale 1ns/1ps
`default_nettype none
module srol_ctrl_model (
  // timing
  input wire logic i_clk,
  // pins toward the device
  output logic o_data,
  output logic o_sclk,
  output logic o_sclr_n,
  output logic o_tclk,
  output logic o_tclr_n
);
  initial begin
    o_data = 1'b0;
    o_sclk = 1'b0;
    o_sclr_n = 1'b1;
    o_tclk = 1'b0;
    o_tclr_n = 1'b1;
  end
  // three cycles per phase: pins pass a two-flop synchroniser
  task automatic pulse(input logic s, input logic t, input logic b);
    @(negedge i_clk) o_data = b;
    repeat (3) @(negedge i_clk);
    o_sclk = s;
    o_tclk = t;
    repeat (3) @(negedge i_clk);
    o_sclk = 1'b0;
    o_tclk = 1'b0;
    repeat (3) @(negedge i_clk);
    o_data = ~b;
  endtask
  // first bit shifted ends in the top stage
  task automatic shift_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, v[i]);
  endtask
  task automatic clr(input logic s, input logic t);
    @(negedge i_clk);
    o_sclr_n = s;
    o_tclr_n = t;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // srol_ctrl_model
`default_nettype wire

// >>> verif/test_srol_top.sv
// self-checking bench for the shift register with output latch
`timescale 1ns/1ps
`default_nettype none
module test_srol_top;
  import srol_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic word_ready = 1'b1;
  logic sdat, sclk, sclr_n, tclk, tclr_n, casc, load_rdy, wvalid;
  logic [7:0] pout, wdata;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  srol_ctrl_model srol_ctrl_model_i (.i_clk(clk), .o_data(sdat),
    .o_sclk(sclk), .o_sclr_n(sclr_n), .o_tclk(tclk), .o_tclr_n(tclr_n));
  srol_top srol_top_i (.i_sys_clk(clk), .i_rstn(rstn), .i_serial_in(sdat),
    .i_shift_clock(sclk), .i_shift_clear_n(sclr_n),
    .i_storage_clock(tclk), .i_storage_clear_n(tclr_n),
    .o_cascade_out(casc), .o_parallel_out(pout), .o_load_ready(load_rdy),
    .o_word_valid(wvalid), .i_word_ready(word_ready), .o_word_data(wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic store();
    srol_ctrl_model_i.pulse(1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_shift_store();
    srol_ctrl_model_i.shift_byte(8'hA5);
    check(pout, 8'h00);
    check({7'h00, casc}, 8'h01);
    store();
    check(pout, 8'hA5);
    check(pout, 8'hA5);
    srol_ctrl_model_i.pulse(1'b1, 1'b0, 1'b0);
    check({7'h00, casc}, 8'h00);
    check(pout, 8'hA5);
  endtask
  task automatic t_tied();
    srol_ctrl_model_i.shift_byte(8'h3C);
    srol_ctrl_model_i.pulse(1'b1, 1'b1, 1'b1);
    check(pout, 8'h3C);
    store();
    check(pout, 8'h79);
  endtask
  task automatic t_clears();
    srol_ctrl_model_i.shift_byte(8'hFF);
    srol_ctrl_model_i.clr(1'b0, 1'b1);
    check({7'h00, casc}, 8'h00);
    srol_ctrl_model_i.pulse(1'b1, 1'b1, 1'b1);
    check(pout, 8'h00);
    srol_ctrl_model_i.clr(1'b1, 1'b1);
    srol_ctrl_model_i.shift_byte(8'hFF);
    store();
    srol_ctrl_model_i.clr(1'b1, 1'b0);
    check(pout, 8'h00);
    store();
    check(pout, 8'h00);
    srol_ctrl_model_i.clr(1'b1, 1'b1);
    store();
    check(pout, 8'hFF);
  endtask
  task automatic t_buffer();
    @(negedge clk) word_ready = 1'b0;
    store();
    srol_ctrl_model_i.pulse(1'b1, 1'b0, 1'b0);
    store();
    srol_ctrl_model_i.pulse(1'b1, 1'b0, 1'b0);
    store();
    check(pout, 8'hFC);
    check({6'h00, load_rdy, wvalid}, 8'h01);
    check(wdata, 8'hFF);
    word_ready = 1'b1;
    @(negedge clk) check(wdata, 8'hFE);
    @(negedge clk) check({7'h00, wvalid}, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    check({6'h00, load_rdy, wvalid}, 8'h02);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    t_shift_store();
    t_tied();
    t_clears();
    t_buffer();
    conclude();
  end
endmodule // test_srol_top
`default_nettype wire
